// ---- logic/ivs_pkg.sv ----
// constants for the input-voltage supervisor register bank
// shared by the supervisor top and its cycle counter
package ivs_pkg;

  // command codes
  localparam logic [7:0]  IVS_CMD_OV_LIMIT    = 8'h55;
  localparam logic [7:0]  IVS_CMD_OV_RESPONSE = 8'h56;
  localparam logic [7:0]  IVS_CMD_UV_LIMIT    = 8'h58;

  // linear-format word layout
  localparam int          IVS_EXP_MSB  = 15;
  localparam int          IVS_EXP_LSB  = 11;
  localparam int          IVS_MAN_MSB  = 10;
  localparam int          IVS_MAN_LSB  = 0;
  localparam logic [4:0]  IVS_EXP_FIXED = 5'h1E;

  // limit mantissas in quarter volts (exponent -2)
  localparam logic [10:0] IVS_MAN_MIN        = 11'h014;
  localparam logic [10:0] IVS_MAN_MAX        = 11'h058;
  localparam logic [10:0] IVS_UV_MAN_RESET   = 11'h00A;
  localparam logic [10:0] IVS_OV_MAN_RESET   = 11'h050;
  localparam int          IVS_QUARTER_SHIFT  = 2;

  // response byte layout
  localparam int          IVS_ACT_MSB   = 7;
  localparam int          IVS_ACT_LSB   = 6;
  localparam int          IVS_RETRY_MSB = 5;
  localparam int          IVS_RETRY_LSB = 3;
  localparam int          IVS_DLY_MSB   = 2;
  localparam int          IVS_DLY_LSB   = 0;
  localparam logic [7:0]  IVS_RESP_RESET = 8'h80;

  localparam logic [1:0]  IVS_ACT_IGNORE    = 2'h0;
  localparam logic [1:0]  IVS_ACT_DELAYED   = 2'h1;
  localparam logic [1:0]  IVS_ACT_IMMEDIATE = 2'h2;
  localparam logic [1:0]  IVS_ACT_INVALID   = 2'h3;

  localparam logic [2:0]  IVS_RETRY_LATCH   = 3'h0;
  localparam logic [2:0]  IVS_RETRY_FOREVER = 3'h7;

  // shutdown delay in pwm clocks per delay code group
  localparam logic [3:0]  IVS_DLY_SHORT = 4'h3;
  localparam logic [3:0]  IVS_DLY_MID   = 4'h5;
  localparam logic [3:0]  IVS_DLY_LONG  = 4'h9;
  localparam logic [2:0]  IVS_DLY_MID_FIRST  = 3'h2;
  localparam logic [2:0]  IVS_DLY_LONG_FIRST = 3'h5;

  typedef enum logic [2:0] {
    IVS_OFF     = 3'b000,
    IVS_RUN     = 3'b001,
    IVS_DELAY   = 3'b010,
    IVS_HICCUP  = 3'b011,
    IVS_LATCHED = 3'b100
  } ivs_state_t;

endpackage

// ---- logic/ivs_cycle_counter.sv ----
// event counter that reports when a programmed number of ticks has passed
// assumes tick is a one-cycle pulse in the clock domain of clock
`timescale 1ns/1ps
module ivs_cycle_counter
  import ivs_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // control
  input  wire logic             restart,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] target,
  // status
  output logic                  reached
);

  logic [WIDTH-1:0] count;

  // restart wins over a tick in the same cycle so a new interval is never short
  always_ff @(posedge clock) begin
    if (rst || restart) begin
      count <= '0;
    end else if (tick && count != target) begin
      count <= count + WIDTH'(1);
    end
  end

  assign reached = (count == target);

endmodule

// ---- logic/ivs_supervisor.sv ----
// input-voltage fault supervisor: limit registers, comparators, status, retry engine
// assumes pmbus transport delivers decoded single-cycle command strobes
// Operation
// - limits held as 16-bit linear words; exponent resets to 11110b
// - response is byte access at 56h; limits use word access
// - overvoltage fault when input voltage exceeds the 55h limit
// - overvoltage limit accepted from 5 V to 22 V in quarter volts
// - out-of-range overvoltage limit write flags invalid data and alerts host
// - restore loads the overvoltage limit as nearest representable value
// - overvoltage fault sets none-of-above, input and ov bits, alerts host
// - action 00 ignore, 01 delayed shutdown, 10 immediate, then retry setting
// - action 11 or other invalid response writes flag invalid data and alert
// - delayed mode keeps switching for delay count, shuts down only if still over
// - retry 0 latches, 1-6 limited hiccup restarts, 7 retries forever
// - restarts while still overvoltage count toward the retry budget
// - delay code picks 3, 5 or 9 pwm clocks and hiccup rise-time multiple
// - with ignore set, an overvoltage at enable still blocks start-up
// - undervoltage warning when input voltage falls below warning limit
// - undervoltage warning judged by this phase alone
// - undervoltage warning sets none-of-above, input and uv bits, alerts host
// - warning limit resets to 2.5 V; writes accepted only from 5 V to 22 V
// - once above 5 V, warning limit can never be set below 5 V
// - invalid warning limit write flags invalid data and alerts host
`timescale 1ns/1ps
module ivs_supervisor
  import ivs_pkg::*;
#(
  parameter logic [10:0] OV_MAN_DEFAULT = IVS_OV_MAN_RESET,
  parameter logic [7:0]  RESP_DEFAULT   = IVS_RESP_RESET,
  parameter int          HICCUP_WIDTH   = 3
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // command write port
  input  wire logic        wr_req,
  input  wire logic        wr_word,
  input  wire logic [7:0]  wr_code,
  input  wire logic [15:0] wr_data,
  // command read port
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_code,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  // non-volatile restore
  input  wire logic        restore,
  input  wire logic [15:0] restore_ov_limit,
  // converter side
  input  wire logic [10:0] power_stage_input_voltage,
  input  wire logic        enable,
  input  wire logic        startup_done,
  input  wire logic        pwm_clock_tick,
  input  wire logic        rise_time_tick,
  output logic             switching_enable,
  // status and host notification
  input  wire logic        clear_faults,
  output logic             status_none_of_above,
  output logic             status_input,
  output logic             status_input_ov_fault,
  output logic             status_input_uv_warn,
  output logic             status_cml,
  output logic             status_cml_invalid_data,
  output logic             alert_n
);

  // register bank
  logic [4:0]  overvoltage_limit_exponent;
  logic [10:0] overvoltage_limit_mantissa;
  logic [7:0]  input_overvoltage_response;
  logic [4:0]  undervoltage_warning_exponent;
  logic [10:0] undervoltage_warning_mantissa;
  logic        uv_limit_raised;

  logic [1:0]  overvoltage_response_action;
  logic [2:0]  overvoltage_retry_count;
  logic [2:0]  overvoltage_delay_select;

  assign overvoltage_response_action = input_overvoltage_response[IVS_ACT_MSB:IVS_ACT_LSB];
  assign overvoltage_retry_count     = input_overvoltage_response[IVS_RETRY_MSB:IVS_RETRY_LSB];
  assign overvoltage_delay_select    = input_overvoltage_response[IVS_DLY_MSB:IVS_DLY_LSB];

  // limit word is valid only in the fixed quarter-volt exponent and 5-22 V
  function automatic logic limit_word_ok(input logic [15:0] w);
    logic [10:0] m;
    m = w[IVS_MAN_MSB:IVS_MAN_LSB];
    return (w[IVS_EXP_MSB:IVS_EXP_LSB] == IVS_EXP_FIXED)
           && (m >= IVS_MAN_MIN) && (m <= IVS_MAN_MAX);
  endfunction

  // convert any linear word to the nearest quarter-volt step inside range
  function automatic logic [10:0] nearest_limit(input logic [15:0] w);
    int m;
    int s;
    int q;
    m = int'($signed(w[IVS_MAN_MSB:IVS_MAN_LSB]));
    s = int'($signed(w[IVS_EXP_MSB:IVS_EXP_LSB])) + IVS_QUARTER_SHIFT;
    if (s >= 0) begin
      q = m <<< s;
    end else begin
      q = (m + (1 <<< (-s - 1))) >>> (-s);
    end
    if (q < int'(IVS_MAN_MIN)) begin
      q = int'(IVS_MAN_MIN);
    end else if (q > int'(IVS_MAN_MAX)) begin
      q = int'(IVS_MAN_MAX);
    end
    return q[10:0];
  endfunction

  function automatic logic [3:0] shutdown_delay(input logic [2:0] code);
    if (code >= IVS_DLY_LONG_FIRST) begin
      return IVS_DLY_LONG;
    end else if (code >= IVS_DLY_MID_FIRST) begin
      return IVS_DLY_MID;
    end
    return IVS_DLY_SHORT;
  endfunction

  function automatic logic [2:0] hiccup_multiple(input logic [2:0] code);
    return (code < IVS_DLY_MID_FIRST) ? 3'h1 : code;
  endfunction

  // write decode
  logic wr_ov;
  logic wr_resp;
  logic wr_uv;
  logic wr_ov_ok;
  logic wr_resp_ok;
  logic wr_uv_ok;
  logic wr_invalid;

  assign wr_ov   = wr_req && (wr_code == IVS_CMD_OV_LIMIT);
  assign wr_resp = wr_req && (wr_code == IVS_CMD_OV_RESPONSE);
  assign wr_uv   = wr_req && (wr_code == IVS_CMD_UV_LIMIT);

  assign wr_ov_ok   = wr_word && limit_word_ok(wr_data);
  assign wr_resp_ok = !wr_word
                      && (wr_data[IVS_ACT_MSB:IVS_ACT_LSB] != IVS_ACT_INVALID);
  // range floor of 5 V also keeps a raised limit from dropping back below it
  assign wr_uv_ok   = wr_word && limit_word_ok(wr_data);
  assign wr_invalid = (wr_ov && !wr_ov_ok) || (wr_resp && !wr_resp_ok)
                      || (wr_uv && !wr_uv_ok);

  always_ff @(posedge clock) begin
    if (rst) begin
      overvoltage_limit_exponent <= IVS_EXP_FIXED;
      overvoltage_limit_mantissa <= OV_MAN_DEFAULT;
    end else if (wr_ov && wr_ov_ok) begin
      overvoltage_limit_exponent <= wr_data[IVS_EXP_MSB:IVS_EXP_LSB];
      overvoltage_limit_mantissa <= wr_data[IVS_MAN_MSB:IVS_MAN_LSB];
    end else if (restore) begin
      overvoltage_limit_exponent <= IVS_EXP_FIXED;
      overvoltage_limit_mantissa <= nearest_limit(restore_ov_limit);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      input_overvoltage_response <= RESP_DEFAULT;
    end else if (wr_resp && wr_resp_ok) begin
      input_overvoltage_response <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      undervoltage_warning_exponent <= IVS_EXP_FIXED;
      undervoltage_warning_mantissa <= IVS_UV_MAN_RESET;
      uv_limit_raised               <= 1'b0;
    end else if (wr_uv && wr_uv_ok && !(uv_limit_raised
                 && wr_data[IVS_MAN_MSB:IVS_MAN_LSB] < IVS_MAN_MIN)) begin
      undervoltage_warning_exponent <= wr_data[IVS_EXP_MSB:IVS_EXP_LSB];
      undervoltage_warning_mantissa <= wr_data[IVS_MAN_MSB:IVS_MAN_LSB];
      uv_limit_raised               <= wr_data[IVS_MAN_MSB:IVS_MAN_LSB] > IVS_MAN_MIN;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        case (rd_code)
          IVS_CMD_OV_LIMIT: begin
            rd_data <= {overvoltage_limit_exponent, overvoltage_limit_mantissa};
          end
          IVS_CMD_OV_RESPONSE: begin
            rd_data <= {8'h00, input_overvoltage_response};
          end
          IVS_CMD_UV_LIMIT: begin
            rd_data <= {undervoltage_warning_exponent, undervoltage_warning_mantissa};
          end
          default: begin
            rd_data <= 16'h0000;
          end
        endcase
      end
    end
  end

  // comparators; this phase looks only at its own input voltage
  logic ov_present;
  logic uv_present;

  assign ov_present = power_stage_input_voltage > overvoltage_limit_mantissa;
  assign uv_present = power_stage_input_voltage < undervoltage_warning_mantissa;

  // sticky status, a new event in the clear cycle survives
  always_ff @(posedge clock) begin
    if (rst) begin
      status_input_ov_fault   <= 1'b0;
      status_input_uv_warn    <= 1'b0;
      status_cml_invalid_data <= 1'b0;
    end else begin
      status_input_ov_fault   <= ov_present || (status_input_ov_fault && !clear_faults);
      status_input_uv_warn    <= uv_present || (status_input_uv_warn && !clear_faults);
      status_cml_invalid_data <= wr_invalid
                                 || (status_cml_invalid_data && !clear_faults);
    end
  end

  assign status_input         = status_input_ov_fault || status_input_uv_warn;
  assign status_none_of_above = status_input;
  assign status_cml           = status_cml_invalid_data;
  assign alert_n              = !(status_input || status_cml);

  // fault response engine
  ivs_state_t state;
  ivs_state_t next_state;
  logic [2:0] attempts;
  logic       count_restart;
  logic       count_tick;
  logic [3:0] count_target;
  logic       count_reached;
  logic       retry_allowed;
  logic       shut_down;

  // hiccup and delay never overlap, so one counter serves both
  ivs_cycle_counter #(
    .WIDTH (4)
  ) u_counter (
    .clock   (clock),
    .rst     (rst),
    .restart (count_restart),
    .tick    (count_tick),
    .target  (count_target),
    .reached (count_reached)
  );

  assign count_tick   = (state == IVS_DELAY) ? pwm_clock_tick : rise_time_tick;
  assign count_target = (state == IVS_DELAY) ? shutdown_delay(overvoltage_delay_select)
                        : {1'b0, hiccup_multiple(overvoltage_delay_select)};
  // a repeated hiccup must start a fresh wait, not reuse the spent count
  assign count_restart = (next_state != state) || (state == IVS_HICCUP && count_reached);

  assign retry_allowed = (overvoltage_retry_count == IVS_RETRY_FOREVER)
                         || (attempts < overvoltage_retry_count);
  assign shut_down     = (overvoltage_retry_count != IVS_RETRY_LATCH) && retry_allowed;

  always_comb begin
    next_state = state;
    case (state)
      IVS_OFF: begin
        if (enable && !ov_present) begin
          next_state = IVS_RUN;
        end else if (enable && overvoltage_response_action != IVS_ACT_IGNORE) begin
          next_state = shut_down ? IVS_HICCUP : IVS_LATCHED;
        end
      end
      IVS_RUN: begin
        if (ov_present && overvoltage_response_action == IVS_ACT_DELAYED) begin
          next_state = IVS_DELAY;
        end else if (ov_present && overvoltage_response_action == IVS_ACT_IMMEDIATE) begin
          next_state = shut_down ? IVS_HICCUP : IVS_LATCHED;
        end
      end
      IVS_DELAY: begin
        if (count_reached) begin
          if (!ov_present) begin
            next_state = IVS_RUN;
          end else begin
            next_state = shut_down ? IVS_HICCUP : IVS_LATCHED;
          end
        end
      end
      IVS_HICCUP: begin
        // a restart into a standing overvoltage is invisible but still spent
        if (count_reached) begin
          if (!ov_present) begin
            next_state = IVS_RUN;
          end else begin
            next_state = (overvoltage_retry_count == IVS_RETRY_FOREVER
                          || attempts + 3'h1 < overvoltage_retry_count)
                         ? IVS_HICCUP : IVS_LATCHED;
          end
        end
      end
      IVS_LATCHED: begin
        next_state = IVS_LATCHED;
      end
      default: begin
        next_state = IVS_OFF;
      end
    endcase
    if (!enable) begin
      next_state = IVS_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= IVS_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      attempts <= 3'h0;
    end else if (!enable || (state == IVS_RUN && startup_done)) begin
      attempts <= 3'h0;
    end else if (state == IVS_HICCUP && count_reached
                 && overvoltage_retry_count != IVS_RETRY_FOREVER) begin
      attempts <= attempts + 3'h1;
    end
  end

  // ignore mode still never leaves off while the fault stands
  assign switching_enable = (state == IVS_RUN) || (state == IVS_DELAY);

endmodule

// ---- sim/ivs_checker.sv ----
// port-level assertions for the input-voltage supervisor
// assumes the supervisor top below; response byte tracked from writes
`timescale 1ns/1ps
module ivs_checker
  import ivs_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // command ports
  input wire logic        wr_req,
  input wire logic        wr_word,
  input wire logic [7:0]  wr_code,
  input wire logic [15:0] wr_data,
  input wire logic        rd_req,
  input wire logic        rd_valid,
  // converter and status
  input wire logic        enable,
  input wire logic        switching_enable,
  input wire logic        status_none_of_above,
  input wire logic        status_input,
  input wire logic        status_input_ov_fault,
  input wire logic        status_input_uv_warn,
  input wire logic        status_cml,
  input wire logic        status_cml_invalid_data,
  input wire logic        alert_n
);
  logic [7:0] resp;
  logic       lim_wr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  assign lim_wr = wr_req && wr_word
                  && (wr_code == IVS_CMD_OV_LIMIT || wr_code == IVS_CMD_UV_LIMIT);

  // shadow of the accepted response byte
  always_ff @(posedge clock) begin
    if (rst) begin
      resp <= IVS_RESP_RESET;
    end else if (wr_req && !wr_word && wr_code == IVS_CMD_OV_RESPONSE
                 && wr_data[7:6] != IVS_ACT_INVALID) begin
      resp <= wr_data[7:0];
    end
  end

  rd_answer_a: assert property (rd_req |=> rd_valid)
    else $error("read answer missing");
  rd_cause_a: assert property (rd_valid |-> $past(rd_req))
    else $error("read answer without request");
  alert_sum_a: assert property (alert_n == !(status_input || status_cml))
    else $error("alert does not follow status");
  input_sum_a: assert property (status_input == (status_input_ov_fault
    || status_input_uv_warn) && status_none_of_above == status_input)
    else $error("summary bits wrong");
  resp_bad_a: assert property (wr_req && !wr_word && wr_code == IVS_CMD_OV_RESPONSE
    && wr_data[7:6] == IVS_ACT_INVALID |=> ##[0:1] status_cml_invalid_data)
    else $error("bad response write not flagged");
  limit_bad_a: assert property (lim_wr && (wr_data[10:0] < IVS_MAN_MIN
    || wr_data[10:0] > IVS_MAN_MAX) |=> ##[0:1] status_cml_invalid_data)
    else $error("bad limit write not flagged");
  ov_stop_a: assert property ($rose(status_input_ov_fault) && $past(switching_enable)
    && resp[7:6] == IVS_ACT_IMMEDIATE |-> !switching_enable)
    else $error("immediate shutdown missed");
  ov_ignore_a: assert property ($rose(status_input_ov_fault) && $past(switching_enable)
    && resp[7:6] == IVS_ACT_IGNORE |-> switching_enable)
    else $error("ignored fault stopped switching");
  off_cmd_a: assert property (!enable |=> !switching_enable)
    else $error("switching while commanded off");

  cover property ($fell(switching_enable));
  cover property ($rose(status_cml_invalid_data));
  cover property ($rose(status_input_uv_warn));
endmodule

bind ivs_supervisor ivs_checker u_checker (
  .clock                   (clock),
  .rst                     (rst),
  .wr_req                  (wr_req),
  .wr_word                 (wr_word),
  .wr_code                 (wr_code),
  .wr_data                 (wr_data),
  .rd_req                  (rd_req),
  .rd_valid                (rd_valid),
  .enable                  (enable),
  .switching_enable        (switching_enable),
  .status_none_of_above    (status_none_of_above),
  .status_input            (status_input),
  .status_input_ov_fault   (status_input_ov_fault),
  .status_input_uv_warn    (status_input_uv_warn),
  .status_cml              (status_cml),
  .status_cml_invalid_data (status_cml_invalid_data),
  .alert_n                 (alert_n)
);

// ---- sim/ivs_host_model.sv ----
// host command master driving the supervisor write and read ports
// assumes the supervisor clock; one transfer at a time
`timescale 1ns/1ps
module ivs_host_model
  import ivs_pkg::*;
(
  // clock
  input  wire logic        clock,
  // write port
  output logic             wr_req,
  output logic             wr_word,
  output logic [7:0]       wr_code,
  output logic [15:0]      wr_data,
  // read port
  output logic             rd_req,
  output logic [7:0]       rd_code,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  initial begin
    {wr_req, wr_word, rd_req} = '0;
    {wr_code, rd_code, wr_data} = '0;
  end

  // limits go as words, the response as a byte
  task automatic write(input logic [7:0] code, input logic [15:0] data);
    @(posedge clock);
    wr_req  <= '1;
    wr_word <= code != IVS_CMD_OV_RESPONSE;
    wr_code <= code;
    wr_data <= data;
    @(posedge clock);
    wr_req  <= '0;
    wr_data <= ~data;
  endtask

  task automatic read(input logic [7:0] code, output logic [15:0] data, output logic ok);
    @(posedge clock);
    rd_req  <= '1;
    rd_code <= code;
    @(posedge clock);
    rd_req  <= '0;
    @(negedge clock);
    ok   = rd_valid;
    data = rd_data;
  endtask
endmodule

// ---- sim/test_ivs_supervisor.sv ----
// self-checking bench for the input-voltage supervisor
// assumes the host model for commands; converter side driven here
`timescale 1ns/1ps
module test_ivs_supervisor
  import ivs_pkg::*;
();
  localparam logic [10:0] NORM = 11'h030;
  localparam logic [10:0] OVER = 11'h048;
  logic        clock, rst, wr_req, wr_word, rd_req, rd_valid, restore, enable, startup_done;
  logic        pwm, rise, clear_faults, sw, nota, s_in, s_ov, s_uv, s_cml, s_bad, alert_n;
  logic [7:0]  wr_code, rd_code;
  logic [15:0] wr_data, rd_data, rst_ov;
  logic [10:0] vin, m;
  int          n_fail, n_tests;
  logic [7:0]  bc[6] = '{8'h55, 8'h55, 8'h58, 8'h58, 8'h55, 8'h56};
  logic [15:0] bd[6] = '{16'hF013, 16'hF059, 16'hF013, 16'hF059, 16'hE840, 16'h00C0};

  ivs_host_model u_host (.clock(clock), .wr_req(wr_req), .wr_word(wr_word),
    .wr_code(wr_code), .wr_data(wr_data), .rd_req(rd_req), .rd_code(rd_code),
    .rd_valid(rd_valid), .rd_data(rd_data));
  ivs_supervisor u_dut (.clock(clock), .rst(rst), .wr_req(wr_req), .wr_word(wr_word),
    .wr_code(wr_code), .wr_data(wr_data), .rd_req(rd_req), .rd_code(rd_code),
    .rd_valid(rd_valid), .rd_data(rd_data), .restore(restore), .restore_ov_limit(rst_ov),
    .power_stage_input_voltage(vin), .enable(enable), .startup_done(startup_done),
    .pwm_clock_tick(pwm), .rise_time_tick(rise), .switching_enable(sw),
    .clear_faults(clear_faults), .status_none_of_above(nota), .status_input(s_in),
    .status_input_ov_fault(s_ov), .status_input_uv_warn(s_uv), .status_cml(s_cml),
    .status_cml_invalid_data(s_bad), .alert_n(alert_n));

  initial begin
    clock = '0;
    forever #2 clock = ~clock;
  end

  function automatic int dly_clks(int c);
    return c < 2 ? 3 : (c < 5 ? 5 : 9);
  endfunction

  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(string what, logic exp, logic got);
    chk16(what, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic rd(logic [7:0] code, logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_host.read(code, d, ok);
    chk1("rd_valid", '1, ok);
    chk16("rd_data", exp, d);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic pulse(int sel, int n);
    repeat (n) begin
      @(posedge clock);
      case (sel)
        0: pwm <= '1;
        1: rise <= '1;
        2: startup_done <= '1;
        3: clear_faults <= '1;
        default: restore <= '1;
      endcase
      @(posedge clock);
      {pwm, rise, startup_done, clear_faults, restore} <= '0;
    end
  endtask
  task automatic drive(logic [10:0] v, logic en);
    @(posedge clock);
    vin    <= v;
    enable <= en;
  endtask
  // off then on clears any latch before each case
  task automatic start();
    drive(NORM, '0);
    settle(2);
    drive(NORM, '1);
    pulse(2, 1);
    pulse(3, 1);
    settle(2);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    results();
  end

  initial begin
    rst = '1;
    vin = NORM;
    rst_ov = '0;
    {enable, startup_done, pwm, rise, clear_faults, restore} = '0;
    void'($urandom(31441));
    repeat (10) @(posedge clock);
    rst <= '0;
    rd(IVS_CMD_OV_LIMIT, 16'hF050);
    rd(IVS_CMD_OV_RESPONSE, 16'h0080);
    rd(IVS_CMD_UV_LIMIT, 16'hF00A);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      m = i == 0 ? 11'h014 : (i == 1 ? 11'h058 : 11'($urandom_range(88, 20)));
      u_host.write(IVS_CMD_OV_LIMIT, {IVS_EXP_FIXED, m});
      rd(IVS_CMD_OV_LIMIT, {IVS_EXP_FIXED, m});
    end
    // limit kept above the start-up input voltage
    u_host.write(IVS_CMD_OV_LIMIT, 16'hF040);
    u_host.write(IVS_CMD_UV_LIMIT, 16'hF020);
    rd(IVS_CMD_UV_LIMIT, 16'hF020);
    $display("test limit writes done");
    for (int i = 0; i < 6; i++) begin
      pulse(3, 1);
      settle(1);
      chk1("invalid_data", '0, s_bad);
      u_host.write(bc[i], bd[i]);
      settle(2);
      chk1("invalid_data", '1, s_bad);
      chk1("alert_n", '0, alert_n);
      chk1("status_cml", '1, s_cml);
    end
    rd(IVS_CMD_OV_LIMIT, 16'hF040);
    rd(IVS_CMD_UV_LIMIT, 16'hF020);
    rd(IVS_CMD_OV_RESPONSE, 16'h0080);
    $display("test invalid writes done");
    start();
    chk1("switching", '1, sw);
    drive(OVER, '1);
    settle(2);
    chk1("switching", '0, sw);
    chk1("ov_fault", '1, s_ov);
    chk1("none_of_above", '1, nota);
    chk1("alert_n", '0, alert_n);
    drive(NORM, '1);
    pulse(1, 4);
    settle(2);
    chk1("switching", '0, sw);
    $display("test immediate latch done");
    for (int c = 0; c < 8; c++) begin
      u_host.write(IVS_CMD_OV_RESPONSE, {8'h0, 2'h1, 3'h0, 3'(c)});
      start();
      drive(OVER, '1);
      pulse(0, dly_clks(c) - 1);
      settle(1);
      chk1("switching", '1, sw);
      pulse(0, 1);
      settle(2);
      chk1("switching", '0, sw);
    end
    // fault gone before the nine-clock count ends: back to running
    start();
    drive(OVER, '1);
    pulse(0, 1);
    drive(NORM, '1);
    pulse(0, 9);
    settle(2);
    chk1("switching", '1, sw);
    $display("test delayed shutdown done");
    u_host.write(IVS_CMD_OV_RESPONSE, 16'h0093);
    start();
    drive(OVER, '1);
    pulse(1, 7);
    drive(NORM, '1);
    pulse(1, 6);
    settle(2);
    chk1("switching", '0, sw);
    u_host.write(IVS_CMD_OV_RESPONSE, 16'h00BB);
    start();
    drive(OVER, '1);
    pulse(1, 9);
    drive(NORM, '1);
    pulse(1, 3);
    settle(2);
    chk1("switching", '1, sw);
    $display("test hiccup retries done");
    u_host.write(IVS_CMD_OV_RESPONSE, 16'h0000);
    drive(OVER, '0);
    settle(2);
    drive(OVER, '1);
    settle(3);
    chk1("switching", '0, sw);
    drive(NORM, '1);
    pulse(3, 1);
    drive(OVER, '1);
    settle(3);
    chk1("switching", '1, sw);
    drive(11'h018, '1);
    pulse(3, 1);
    settle(2);
    chk1("uv_warn", '1, s_uv);
    chk1("status_input", '1, s_in);
    chk1("alert_n", '0, alert_n);
    $display("test ignore and warning done");
    @(posedge clock);
    rst_ov <= 16'hF010;
    pulse(4, 1);
    settle(2);
    rd(IVS_CMD_OV_LIMIT, 16'hF014);
    $display("test restore done");
    results();
  end
endmodule
